// ==== verilog/asb_sample_buffer.sv ====
// acceleration sample buffer with fifo, stream, trigger and newest-first modes
`timescale 1ns/1ps
`default_nettype none
module asb_sample_buffer
  import asb_pkg::*;
#(
  parameter int DEPTH = ASB_CAP_LO
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sample_valid,
  input  wire logic [11:0] sample_x,
  input  wire logic [11:0] sample_y,
  input  wire logic [11:0] sample_z,
  input  wire logic        trigger_event,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        readout_active,
  input  wire logic        scl,
  output logic             watermark
);
  localparam int PW = $clog2(DEPTH);

  // seven-bit set count limits the depth; below the low-res capacity the array cannot hold a full buffer
  if (DEPTH < ASB_CAP_LO || DEPTH > 127) begin : g_depth_check
    $error("asb: DEPTH must be 84..127");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [6:0]   threshold_ff;
  logic         buffer_active_ff;
  logic         sample_width_select_ff;
  asb_mode_type mode_ff;
  logic         trigger_seen_flag_ff;
  logic [7:0]   reg_rdata_ff;

  wire wr_threshold = reg_wr & (reg_addr == ASB_OFS_THRESHOLD);
  wire wr_control   = reg_wr & (reg_addr == ASB_OFS_CONTROL);
  wire wr_flush     = reg_wr & (reg_addr == ASB_OFS_FLUSH);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      threshold_ff           <= ASB_THRESHOLD_RST[6:0];
      buffer_active_ff       <= ASB_CONTROL_RST[ASB_BIT_ACTIVE];
      sample_width_select_ff <= ASB_CONTROL_RST[ASB_BIT_WIDTH];
      mode_ff                <= ASB_MODE_FIFO;
    end else begin
      if (wr_threshold) threshold_ff <= reg_wdata[6:0];
      if (wr_control) begin
        buffer_active_ff       <= reg_wdata[ASB_BIT_ACTIVE];
        sample_width_select_ff <= reg_wdata[ASB_BIT_WIDTH];
        mode_ff                <= asb_mode_type'(reg_wdata[1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage state
  logic [35:0]   mem [DEPTH];
  logic [PW-1:0] rd_ptr_ff;
  logic [PW-1:0] wr_ptr_ff;
  logic [6:0]    count_ff;
  logic          pend_ff;
  logic [35:0]   pend_data_ff;
  logic [2:0]    byte_idx_ff;
  logic [3:0]    scl_cnt_ff;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  function automatic logic [PW-1:0] ptr_dec(input logic [PW-1:0] p);
    ptr_dec = (p == '0) ? PW'(DEPTH - 1) : p - PW'(1);
  endfunction

  wire [6:0] capacity = sample_width_select_ff ? 7'(ASB_CAP_HI) : 7'(ASB_CAP_LO);
  wire       full     = count_ff >= capacity;
  wire       trig_mode   = (mode_ff == ASB_MODE_TRIG);
  wire       newest_first_mode = (mode_ff == ASB_MODE_NEWEST);
  wire       pre_trigger = trig_mode & ~trigger_seen_flag_ff;
  wire [6:0] pre_limit   = (threshold_ff < capacity) ? threshold_ff : capacity;
  // overwrite modes: stream, newest-first, and trigger before its event
  wire       overwrite   = (mode_ff == ASB_MODE_STREAM) | newest_first_mode | pre_trigger;
  wire [6:0] keep_limit  = pre_trigger ? pre_limit : capacity;
  wire       at_limit    = count_ff >= keep_limit;

  // a set taken during readout waits in pend_ff, so the array is never written mid-read
  wire can_store = buffer_active_ff & pend_ff & ~readout_active & ~wr_flush;
  wire do_write  = can_store & (overwrite ? (keep_limit != 7'h00) : ~full);
  wire do_drop   = do_write & overwrite & at_limit;

  ////////////////////////////////////////////////////////////////////////////
  // readout: bytes advance on every ninth falling scl edge of a read
  logic scl_fall;

  asb_edge_sync u_scl_sync (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .pin_in     (scl),
    .fall_pulse (scl_fall)
  );

  wire [2:0]    set_bytes = sample_width_select_ff ? ASB_BYTES_HI : ASB_BYTES_LO;
  wire          byte_done = readout_active & scl_fall & (scl_cnt_ff == ASB_SCL_PER_BYTE - 4'h1);
  wire          last_byte = (byte_idx_ff == set_bytes - 3'h1);
  wire          do_pop    = byte_done & last_byte & (count_ff != 7'h00) & ~wr_flush;
  wire [PW-1:0] rd_addr   = newest_first_mode ? ptr_dec(wr_ptr_ff) : rd_ptr_ff;
  wire [35:0]   head_set  = mem[rd_addr];

  function automatic logic [7:0] pick_byte(input logic [35:0] s, input logic hi_res, input logic [2:0] idx);
    logic [11:0] axis;
    axis = 12'h000;
    if (hi_res) begin
      case (idx[2:1])
        2'b00:   axis = s[35:24];
        2'b01:   axis = s[23:12];
        default: axis = s[11:0];
      endcase
      pick_byte = idx[0] ? axis[11:4] : {axis[3:0], 4'h0};
    end else begin
      case (idx)
        3'h0:    axis = s[35:24];
        3'h1:    axis = s[23:12];
        default: axis = s[11:0];
      endcase
      pick_byte = axis[11:4];
    end
  endfunction

  wire [7:0] readout_byte = (count_ff == 7'h00) ? 8'h00 : pick_byte(head_set, sample_width_select_ff, byte_idx_ff);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_cnt_ff  <= 4'h0;
      byte_idx_ff <= 3'h0;
    end else if (!readout_active) begin
      scl_cnt_ff  <= 4'h0;
      byte_idx_ff <= 3'h0;
    end else if (scl_fall) begin
      scl_cnt_ff <= (scl_cnt_ff == ASB_SCL_PER_BYTE - 4'h1) ? 4'h0 : scl_cnt_ff + 4'h1;
      if (byte_done) byte_idx_ff <= last_byte ? 3'h0 : byte_idx_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointers, count, pending set and trigger flag
  always_ff @(posedge mclk) begin
    if (do_write) mem[wr_ptr_ff] <= pend_data_ff;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff      <= 1'b0;
      pend_data_ff <= 36'h0;
    end else begin
      if (sample_valid) pend_data_ff <= {sample_x, sample_y, sample_z};
      // a new sample wins over a flush or a commit in the same cycle
      if (sample_valid) pend_ff <= 1'b1;
      // an inactive buffer drops the set, so a stale one cannot land on activation
      else if (wr_flush || can_store || !buffer_active_ff) pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      count_ff  <= 7'h00;
    end else if (wr_flush) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      count_ff  <= 7'h00;
    end else if (do_write) begin
      wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      if (do_drop) rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      else count_ff <= count_ff + 7'h01;
    end else if (do_pop) begin
      count_ff <= count_ff - 7'h01;
      if (newest_first_mode) wr_ptr_ff <= ptr_dec(wr_ptr_ff);
      else rd_ptr_ff <= ptr_inc(rd_ptr_ff);
    end
  end

  wire trig_set = buffer_active_ff & trig_mode & trigger_event;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) trigger_seen_flag_ff <= 1'b0;
    else if (trig_set) trigger_seen_flag_ff <= 1'b1;
    else if (wr_flush || !trig_mode) trigger_seen_flag_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and watermark
  // widen before the product: 84 sets of 3 bytes needs all eight bits
  wire [7:0] fill_byte_count = {1'b0, count_ff} * {5'h00, set_bytes};
  wire [7:0] control_value   = {buffer_active_ff, sample_width_select_ff, 4'h0, mode_ff};
  wire [7:0] trig_status     = {trigger_seen_flag_ff & trig_mode, 7'h00};
  logic [7:0] read_value;

  always_comb begin
    case (reg_addr)
      ASB_OFS_THRESHOLD: read_value = {1'b0, threshold_ff};
      ASB_OFS_CONTROL:   read_value = control_value;
      ASB_OFS_FILL:      read_value = fill_byte_count;
      ASB_OFS_TRIG_STAT: read_value = trig_status;
      ASB_OFS_READOUT:   read_value = readout_byte;
      default:           read_value = 8'h00;
    endcase
  end

  logic watermark_ff;
  wire  wmk_mode = buffer_active_ff & ~trig_mode;
  wire  nxt_watermark = wmk_mode & (count_ff >= threshold_ff);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
      watermark_ff <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata_ff <= read_value;
      watermark_ff <= nxt_watermark;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign watermark = watermark_ff;
endmodule // asb_sample_buffer
`default_nettype wire

// ==== verilog/asb_pkg.sv ====
// constants, types and register map of the acceleration sample buffer
// Overview of operation
// - seven-bit threshold sets stored-set count for watermark in fifo, stream, newest-first
// - capacity is 41 sets at 12-bit, 84 sets at 8-bit resolution
// - in trigger mode threshold gives the number of pre-trigger sets kept
// - control bit 7 activates the buffer; cleared leaves it inactive
// - width select: 0 stores 8-bit samples, 1 stores 12-bit samples
// - mode 00 fills to capacity, then stores nothing until not full
// - mode 01 keeps newest sets; when full the oldest is dropped
// - mode 10 keeps threshold pre-trigger sets, then fills to capacity and stops
// - mode 11 overwrites like stream and reads out newest set first
// - fill level counts bytes: 6 per set at 12-bit, 3 at 8-bit
// - fill level reads zero whenever the buffer holds no data
// - trigger status bit 7 shows trigger state in trigger mode; rest zero
// - any write to the flush register empties buffer and clears latched status, unless a trigger event arrives in the same cycle
// - no sample is stored while an auto-increment readout runs
package asb_pkg;
  localparam logic [7:0] ASB_OFS_THRESHOLD = 8'h32;
  localparam logic [7:0] ASB_OFS_CONTROL   = 8'h33;
  localparam logic [7:0] ASB_OFS_FILL      = 8'h34;
  localparam logic [7:0] ASB_OFS_TRIG_STAT = 8'h35;
  localparam logic [7:0] ASB_OFS_FLUSH     = 8'h36;
  localparam logic [7:0] ASB_OFS_READOUT   = 8'h7f;

  localparam logic [7:0] ASB_THRESHOLD_RST = 8'h00;
  localparam logic [7:0] ASB_CONTROL_RST   = 8'h00;

  localparam int ASB_BIT_ACTIVE = 7;
  localparam int ASB_BIT_WIDTH  = 6;
  localparam int ASB_BIT_TRIG   = 7;

  localparam int ASB_CAP_HI = 41;
  localparam int ASB_CAP_LO = 84;

  localparam logic [2:0] ASB_BYTES_HI = 3'h6;
  localparam logic [2:0] ASB_BYTES_LO = 3'h3;

  // eight data bits plus acknowledge per byte on the serial link
  localparam logic [3:0] ASB_SCL_PER_BYTE = 4'h9;

  typedef enum logic [1:0] {
    ASB_MODE_FIFO   = 2'b00,
    ASB_MODE_STREAM = 2'b01,
    ASB_MODE_TRIG   = 2'b10,
    ASB_MODE_NEWEST = 2'b11
  } asb_mode_type;
endpackage

// ==== verilog/asb_edge_sync.sv ====
// two-flop synchroniser with falling-edge detector for the serial clock
`timescale 1ns/1ps
`default_nettype none
module asb_edge_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      fall_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign fall_pulse = prev_ff & ~sync_ff;
endmodule // asb_edge_sync
`default_nettype wire

// ==== dv/asb_sample_buffer_sva.sv ====
// port-level assertion checker for the sample buffer
`timescale 1ns/1ps
`default_nettype none
module asb_chk #(
  parameter int DEPTH = 84
) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        sample_valid,
  input wire logic [11:0] sample_x,
  input wire logic [11:0] sample_y,
  input wire logic [11:0] sample_z,
  input wire logic        trigger_event,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        readout_active,
  input wire logic        scl,
  input wire logic        watermark
);
  logic [7:0] ctl_ff;
  logic [7:0] thr_ff;
  wire        wm_ok = ctl_ff[7] && ctl_ff[1:0] != 2'b10;
  // shadow of the control fields, since watermark depends on them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_ff <= 8'h00;
      thr_ff <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h33) ctl_ff <= reg_wdata;
      if (reg_addr == 8'h32) thr_ff <= {1'b0, reg_wdata[6:0]};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_ctl_back: assert property (reg_rd && reg_addr == 8'h33 |=> reg_rdata == ($past(ctl_ff) & 8'hc3))
    else $error("control readback wrong");
  chk_thr_back: assert property (reg_rd && reg_addr == 8'h32 |=> reg_rdata == $past(thr_ff))
    else $error("threshold readback wrong");
  chk_trig_stat: assert property (reg_rd && reg_addr == 8'h35 |=> reg_rdata[6:0] == 7'h00 &&
    (!reg_rdata[7] || $past(ctl_ff[1:0]) == 2'b10)) else $error("trigger status wrong");
  chk_flush_rd: assert property (reg_rd && reg_addr == 8'h36 |=> reg_rdata == 8'h00)
    else $error("flush register read nonzero");
  chk_fill_unit: assert property (reg_rd && reg_addr == 8'h34 |=> reg_rdata % 8'h03 == 8'h00)
    else $error("fill level not whole sets");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[8'h32:8'h36], 8'h7f}) |=>
    reg_rdata == 8'h00) else $error("unmapped read nonzero");
  chk_wm_cause: assert property (watermark |-> $past(wm_ok) || $past(wm_ok, 2))
    else $error("watermark while inactive or in trigger mode");
  chk_wm_thr_zero: assert property ((wm_ok && thr_ff == 8'h00) [*3] |-> watermark)
    else $error("watermark missing at zero threshold");
  chk_wm_flush: assert property (reg_wr && reg_addr == 8'h36 && thr_ff > 8'h01 && !sample_valid
    |-> ##[1:3] !watermark) else $error("watermark kept after flush");
  cover property (watermark);
  cover property (reg_wr && reg_addr == 8'h36);
  cover property (readout_active);
endmodule // asb_chk
bind asb_sample_buffer asb_chk #(.DEPTH(DEPTH)) chk_u (.mclk(mclk), .rst_b(rst_b),
  .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
  .trigger_event(trigger_event), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .readout_active(readout_active), .scl(scl),
  .watermark(watermark));
`default_nettype wire

// ==== dv/asb_host_model.sv ====
// host model clocking whole sets out of the readout address
`timescale 1ns/1ps
`default_nettype none
module asb_host_model (
  input  wire logic       mclk,
  input  wire logic       start,
  input  wire logic [5:0] n_bytes,
  output logic            readout_active,
  output logic            scl,
  output logic            done
);
  initial begin
    readout_active = 1'b0;
    scl = 1'b1;
    done = 1'b0;
  end
  // scl rests high between frames; odd offset puts every scl edge 0.5 ns before a rising mclk edge
  always @(posedge start) begin
    @(negedge mclk);
    done = 1'b0;
    readout_active = 1'b1;
    #37;
    repeat (9 * n_bytes) begin
      #100 scl = 1'b0;
      #100 scl = 1'b1;
    end
    repeat (8) @(negedge mclk);
    readout_active = 1'b0;
    done = 1'b1;
  end
endmodule // asb_host_model
`default_nettype wire

// ==== dv/tb_accel_sample_buffer.sv ====
// self-checking bench for the acceleration sample buffer
`timescale 1ns/1ps
`default_nettype none
module tb_accel_sample_buffer;
  import asb_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sample_valid = 1'b0;
  logic [11:0] sample_x = 12'h000;
  logic [11:0] sample_y = 12'h000;
  logic [11:0] sample_z = 12'h000;
  logic        trigger_event = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        readout_active;
  logic        scl;
  logic        watermark;
  logic        go = 1'b0;
  logic        done;
  int          mismatches = 0;
  int          checked = 0;
  always #12.5 mclk = ~mclk;
  asb_sample_buffer #(.DEPTH(ASB_CAP_LO)) dut_u (.mclk(mclk), .rst_b(rst_b), .sample_valid(sample_valid),
    .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .trigger_event(trigger_event),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .readout_active(readout_active), .scl(scl), .watermark(watermark));
  asb_host_model host_u (.mclk(mclk), .start(go), .n_bytes(6'h03), .readout_active(readout_active),
    .scl(scl), .done(done));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    check(what, reg_rdata, exp);
  endtask
  // x carries the push index so stored order is visible at readout
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      sample_x = {i[7:0], 4'h0};
      sample_y = ~sample_x;
      sample_z = sample_x;
      sample_valid = 1'b1;
      @(negedge mclk);
      sample_valid = 1'b0;
    end
    repeat (3) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd("threshold", 8'h32, 8'h00);
    rd("control", 8'h33, 8'h00);
    rd("fill", 8'h34, 8'h00);
    rd("trig", 8'h35, 8'h00);
    rd("flush", 8'h36, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    push(1);
    rd("inactive fill", 8'h34, 8'h00);
  endtask
  task automatic t_fifo();
    wr(8'h32, 8'hff);
    rd("thr mask", 8'h32, 8'h7f);
    wr(8'h32, 8'h03);
    wr(8'h33, 8'h80);
    push(2);
    check("wm low", {7'h00, watermark}, 8'h00);
    push(1);
    check("wm high", {7'h00, watermark}, 8'h01);
    rd("fill three", 8'h34, 8'h09);
    push(84);
    rd("fifo full", 8'h34, 8'hfc);
    rd("fifo oldest", 8'h7f, 8'h00);
    wr(8'h36, 8'h00);
    rd("flushed", 8'h34, 8'h00);
  endtask
  task automatic t_hires();
    wr(8'h33, 8'hfc);
    rd("ctl mask", 8'h33, 8'hc0);
    push(42);
    rd("hi full", 8'h34, 8'hf6);
    wr(8'h36, 8'h00);
    wr(8'h33, 8'h40);
    push(1);
    rd("off fill", 8'h34, 8'h00);
  endtask
  task automatic t_stream();
    wr(8'h32, 8'h00);
    wr(8'h33, 8'h81);
    push(90);
    rd("stream fill", 8'h34, 8'hfc);
    rd("stream oldest", 8'h7f, 8'h06);
    wr(8'h36, 8'h00);
  endtask
  task automatic t_trig();
    wr(8'h32, 8'h02);
    wr(8'h33, 8'h82);
    push(5);
    rd("pre fill", 8'h34, 8'h06);
    rd("no trig", 8'h35, 8'h00);
    @(negedge mclk);
    trigger_event = 1'b1;
    @(negedge mclk);
    trigger_event = 1'b0;
    rd("trig seen", 8'h35, 8'h80);
    push(90);
    rd("trig full", 8'h34, 8'hfc);
    rd("pre oldest", 8'h7f, 8'h03);
    wr(8'h36, 8'h00);
    rd("trig clear", 8'h35, 8'h00);
    rd("trig empty", 8'h34, 8'h00);
  endtask
  task automatic t_newest();
    wr(8'h33, 8'h83);
    push(2);
    rd("newest", 8'h7f, 8'h01);
    @(negedge mclk);
    go = 1'b1;
    // a set arriving mid-readout must wait until the read ends
    repeat (10) @(negedge mclk);
    sample_x = 12'h550;
    sample_valid = 1'b1;
    @(negedge mclk);
    sample_valid = 1'b0;
    rd("held fill", 8'h34, 8'h06);
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(negedge mclk);
    if (done !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    rd("after pop", 8'h7f, 8'h55);
    rd("pop fill", 8'h34, 8'h06);
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    t_reset();
    t_fifo();
    t_hires();
    t_stream();
    t_trig();
    t_newest();
    print_verdict();
  end
endmodule // tb_accel_sample_buffer
`default_nettype wire
